/* common/fcd_consts.vh */
// Operation
// - Command cycles are writes; only array reads and identification reads are read cycles.
// - Array reads are plain single read cycles without any preceding writes.
// - Single F0 write returns bank to read; host issues it to leave identification.
// - Identification entry: two unlocks, 90 to bank unlock address, then bank reads.
// - Device identifier is read at word offsets 01, 0E and 0F of the bank.
// - Secured region entry: unlocks then 88; exit: unlocks, 90, then 00.
// - Program: AA to 555, 55 to 2AA, A0 to 555, then data.
// - Bypass mode entered by unlocks then 20; needed before bypass program.
// - Bypass program: A0 to any address, then data to target.
// - Bypass mode left by writing 90 then 00 to any address.
// - Erase: AA,55,80,AA,55 then 10 for chip or 30 to sector.
// - Further sectors in collection window take one write of 30 each.
// - Suspend B0 only during sector erase; resume 30 only while suspended.
`ifndef FCD_CONSTS_VH
`define FCD_CONSTS_VH
`define FCD_AW           21
`define FCD_DW           16
`define FCD_CLK_NS       50
`define FCD_WINDOW_NS    50000
`define FCD_WINDOW_CYC   ((`FCD_WINDOW_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`define FCD_SETUP_CYC    4'h2
`define FCD_PULSE_CYC    4'h3
`define FCD_HOLD_CYC     4'h2
`define FCD_ADDR_555     21'h000555
`define FCD_ADDR_2AA     21'h0002aa
`define FCD_ADDR_55      21'h000055
`define FCD_BANK_LSB     18
`define FCD_OFS_MFR      21'h000000
`define FCD_OFS_ID1      21'h000001
`define FCD_OFS_PROT     21'h000002
`define FCD_OFS_SECR     21'h000003
`define FCD_OFS_ID2      21'h00000e
`define FCD_OFS_ID3      21'h00000f
`define FCD_D_UNLK1      16'h00aa
`define FCD_D_UNLK2      16'h0055
`define FCD_D_RESET      16'h00f0
`define FCD_D_IDENT      16'h0090
`define FCD_D_SECR       16'h0088
`define FCD_D_EXIT       16'h0000
`define FCD_D_PROG       16'h00a0
`define FCD_D_BYPASS     16'h0020
`define FCD_D_ERASE      16'h0080
`define FCD_D_CHIP       16'h0010
`define FCD_D_SECT       16'h0030
`define FCD_D_SUSP       16'h00b0
`define FCD_D_QUERY      16'h0098
`define FCD_OP_RESET     4'h0
`define FCD_OP_READ      4'h1
`define FCD_OP_IDENT     4'h2
`define FCD_OP_SECR_IN   4'h3
`define FCD_OP_SECR_OUT  4'h4
`define FCD_OP_PROG      4'h5
`define FCD_OP_BYP_IN    4'h6
`define FCD_OP_BYP_PROG  4'h7
`define FCD_OP_BYP_OUT   4'h8
`define FCD_OP_CHIP_ER   4'h9
`define FCD_OP_SECT_ER   4'ha
`define FCD_OP_SECT_ADD  4'hb
`define FCD_OP_SUSPEND   4'hc
`define FCD_OP_RESUME    4'hd
`define FCD_OP_QUERY     4'he
`endif

/* hdl/fcd_bus_cycle.v */
`include "fcd_consts.vh"

// One asynchronous bus cycle on the flash pins, timed in clock cycles
module fcd_bus_cycle
(
	// Clock and reset
	input  wire                    clk,
	input  wire                    resetn,
	// Cycle request
	input  wire                    start,
	input  wire                    is_read,
	input  wire [`FCD_AW-1:0]      addr,
	input  wire [`FCD_DW-1:0]      wdata,
	output reg                     done_r,
	output reg  [`FCD_DW-1:0]      rdata_r,
	// Flash pins
	output reg  [`FCD_AW-1:0]      f_addr_r,
	output reg                     f_ce_n_r,
	output reg                     f_we_n_r,
	output reg                     f_oe_n_r,
	output reg  [`FCD_DW-1:0]      f_dq_out_r,
	output reg                     f_dq_oe_n_r,
	input  wire [`FCD_DW-1:0]      f_dq_in
);
	localparam PH_IDLE  = 2'h0;
	localparam PH_SETUP = 2'h1;
	localparam PH_PULSE = 2'h2;
	localparam PH_HOLD  = 2'h3;

	reg [1:0] ph_r;
	reg [3:0] cnt_r;
	reg       rd_r;

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ph_r        <= PH_IDLE;
			cnt_r       <= 4'h0;
			rd_r        <= 1'b0;
			done_r      <= 1'b0;
			rdata_r     <= 16'h0000;
			f_addr_r    <= 21'h000000;
			f_ce_n_r    <= 1'b1;
			f_we_n_r    <= 1'b1;
			f_oe_n_r    <= 1'b1;
			f_dq_out_r  <= 16'h0000;
			f_dq_oe_n_r <= 1'b1;
		end
		else
		begin
			done_r <= 1'b0;
			case (ph_r)
				PH_IDLE:
				begin
					if (start)
					begin
						// Address and chip enable settle before the strobe falls
						f_addr_r    <= addr;
						f_ce_n_r    <= 1'b0;
						rd_r        <= is_read;
						f_dq_out_r  <= wdata;
						f_dq_oe_n_r <= is_read;
						cnt_r       <= `FCD_SETUP_CYC;
						ph_r        <= PH_SETUP;
					end
				end
				PH_SETUP:
				begin
					if (cnt_r == 4'h1)
					begin
						// Strobe falls after chip enable: address latched here
						f_we_n_r <= rd_r;
						f_oe_n_r <= ~rd_r;
						cnt_r    <= `FCD_PULSE_CYC;
						ph_r     <= PH_PULSE;
					end
					else
						cnt_r <= cnt_r - 4'h1;
				end
				PH_PULSE:
				begin
					if (cnt_r == 4'h1)
					begin
						// Strobe rises before chip enable: data latched here
						if (rd_r)
							rdata_r <= f_dq_in;
						f_we_n_r <= 1'b1;
						f_oe_n_r <= 1'b1;
						cnt_r    <= `FCD_HOLD_CYC;
						ph_r     <= PH_HOLD;
					end
					else
						cnt_r <= cnt_r - 4'h1;
				end
				PH_HOLD:
				begin
					if (cnt_r == 4'h1)
					begin
						f_ce_n_r    <= 1'b1;
						f_dq_oe_n_r <= 1'b1;
						done_r      <= 1'b1;
						ph_r        <= PH_IDLE;
					end
					else
						cnt_r <= cnt_r - 4'h1;
				end
				default:
					ph_r <= PH_IDLE;
			endcase
		end
	end
endmodule // fcd_bus_cycle

/* hdl/fcd_host.v */
`include "fcd_consts.vh"

// Host-side sequencer: turns one operation request into its flash cycle sequence
module fcd_host
(
	// Clock and reset
	input  wire                    clk,
	input  wire                    resetn,
	// Operation request
	input  wire                    op_valid,
	input  wire [3:0]              op_code,
	input  wire [`FCD_AW-1:0]      op_addr,
	input  wire [`FCD_DW-1:0]      op_data,
	output reg                     op_ready_r,
	output reg                     op_done_r,
	output reg  [`FCD_DW-1:0]      rd_data_r,
	output reg                     rd_valid_r,
	output reg                     window_open_r,
	// Flash pins
	output wire [`FCD_AW-1:0]      f_addr,
	output wire                    f_ce_n,
	output wire                    f_we_n,
	output wire                    f_oe_n,
	output wire [`FCD_DW-1:0]      f_dq_out,
	output wire                    f_dq_oe_n,
	input  wire [`FCD_DW-1:0]      f_dq_in
);
	localparam S_IDLE = 2'h0;
	localparam S_ISSUE = 2'h1;
	localparam S_WAIT = 2'h2;

	localparam [15:0] WIN_CYC = `FCD_WINDOW_CYC;

	reg [1:0]         st_r;
	reg [3:0]         op_r;
	reg [`FCD_AW-1:0] a_r;
	reg [`FCD_DW-1:0] d_r;
	reg [2:0]         idx_r;
	reg [15:0]        win_r;
	reg               bc_start_r;
	reg               bc_read_r;
	reg [`FCD_AW-1:0] bc_addr_r;
	reg [`FCD_DW-1:0] bc_data_r;
	wire              bc_done;
	wire [`FCD_DW-1:0] bc_rdata;

	// Bank base: keep only the bank-select bits of the address
	function [`FCD_AW-1:0] bank_of;
		input [`FCD_AW-1:0] a;
		begin
			bank_of = {a[`FCD_AW-1:`FCD_BANK_LSB], {`FCD_BANK_LSB{1'b0}}};
		end
	endfunction

	// Per-op cycle count
	function [2:0] len_of;
		input [3:0] op;
		begin
			case (op)
				`FCD_OP_RESET, `FCD_OP_READ, `FCD_OP_SECT_ADD,
				`FCD_OP_SUSPEND, `FCD_OP_RESUME, `FCD_OP_QUERY: len_of = 3'h1;
				`FCD_OP_BYP_PROG, `FCD_OP_BYP_OUT:              len_of = 3'h2;
				`FCD_OP_SECR_IN, `FCD_OP_BYP_IN:                len_of = 3'h3;
				`FCD_OP_IDENT, `FCD_OP_SECR_OUT, `FCD_OP_PROG:  len_of = 3'h4;
				`FCD_OP_CHIP_ER, `FCD_OP_SECT_ER:               len_of = 3'h6;
				default:                                        len_of = 3'h1;
			endcase
		end
	endfunction

	// Cycle idx of op: {read, address, data}
	reg               c_rd;
	reg [`FCD_AW-1:0] c_a;
	reg [`FCD_DW-1:0] c_d;
	always @*
	begin
		c_rd = 1'b0;
		c_a  = `FCD_ADDR_555;
		c_d  = `FCD_D_UNLK1;
		// Unlock pairs at cycles 0,1 and, for erase, 3,4
		if (idx_r == 3'h1 || idx_r == 3'h4)
		begin
			c_a = `FCD_ADDR_2AA;
			c_d = `FCD_D_UNLK2;
		end
		case (op_r)
			`FCD_OP_RESET:
			begin
				c_a = a_r;
				c_d = `FCD_D_RESET;
			end
			`FCD_OP_READ:
			begin
				c_rd = 1'b1;
				c_a  = a_r;
			end
			`FCD_OP_IDENT:
				if (idx_r == 3'h2)
				begin
					c_a = bank_of(a_r) | `FCD_ADDR_555;
					c_d = `FCD_D_IDENT;
				end
				else if (idx_r == 3'h3)
				begin
					// Identification read; op_addr holds bank or sector plus offset
					c_rd = 1'b1;
					c_a  = a_r;
				end
			`FCD_OP_SECR_IN:
				if (idx_r == 3'h2)
					c_d = `FCD_D_SECR;
			`FCD_OP_SECR_OUT:
				if (idx_r == 3'h2)
					c_d = `FCD_D_IDENT;
				else if (idx_r == 3'h3)
				begin
					c_a = a_r;
					c_d = `FCD_D_EXIT;
				end
			`FCD_OP_PROG:
				if (idx_r == 3'h2)
					c_d = `FCD_D_PROG;
				else if (idx_r == 3'h3)
				begin
					c_a = a_r;
					c_d = d_r;
				end
			`FCD_OP_BYP_IN:
				if (idx_r == 3'h2)
					c_d = `FCD_D_BYPASS;
			`FCD_OP_BYP_PROG:
			begin
				c_a = a_r;
				c_d = (idx_r == 3'h0) ? `FCD_D_PROG : d_r;
			end
			`FCD_OP_BYP_OUT:
			begin
				c_a = a_r;
				c_d = (idx_r == 3'h0) ? `FCD_D_IDENT : `FCD_D_EXIT;
			end
			`FCD_OP_CHIP_ER, `FCD_OP_SECT_ER:
				if (idx_r == 3'h2)
					c_d = `FCD_D_ERASE;
				else if (idx_r == 3'h5)
				begin
					c_a = (op_r == `FCD_OP_SECT_ER) ? a_r : `FCD_ADDR_555;
					c_d = (op_r == `FCD_OP_SECT_ER) ? `FCD_D_SECT : `FCD_D_CHIP;
				end
			`FCD_OP_SECT_ADD:
			begin
				c_a = a_r;
				c_d = `FCD_D_SECT;
			end
			`FCD_OP_SUSPEND:
			begin
				c_a = bank_of(a_r);
				c_d = `FCD_D_SUSP;
			end
			`FCD_OP_RESUME:
			begin
				c_a = bank_of(a_r);
				c_d = `FCD_D_SECT;
			end
			`FCD_OP_QUERY:
			begin
				c_a = `FCD_ADDR_55;
				c_d = `FCD_D_QUERY;
			end
			default:
			begin
				c_a = a_r;
				c_d = `FCD_D_RESET;
			end
		endcase
	end

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r          <= S_IDLE;
			op_r          <= 4'h0;
			a_r           <= 21'h000000;
			d_r           <= 16'h0000;
			idx_r         <= 3'h0;
			win_r         <= 16'h0000;
			bc_start_r    <= 1'b0;
			bc_read_r     <= 1'b0;
			bc_addr_r     <= 21'h000000;
			bc_data_r     <= 16'h0000;
			op_ready_r    <= 1'b0;
			op_done_r     <= 1'b0;
			rd_data_r     <= 16'h0000;
			rd_valid_r    <= 1'b0;
			window_open_r <= 1'b0;
		end
		else
		begin
			bc_start_r <= 1'b0;
			op_done_r  <= 1'b0;
			rd_valid_r <= 1'b0;
			// Collection window: further sectors must follow within it
			if (win_r != 16'h0000)
				win_r <= win_r - 16'h0001;
			window_open_r <= (win_r > 16'h0001);
			case (st_r)
				S_IDLE:
				begin
					op_ready_r <= 1'b1;
					if (op_valid && op_ready_r)
					begin
						op_ready_r <= 1'b0;
						op_r       <= op_code;
						a_r        <= op_addr;
						d_r        <= op_data;
						idx_r      <= 3'h0;
						st_r       <= S_ISSUE;
					end
				end
				S_ISSUE:
				begin
					bc_start_r <= 1'b1;
					bc_read_r  <= c_rd;
					bc_addr_r  <= c_a;
					bc_data_r  <= c_d;
					st_r       <= S_WAIT;
				end
				S_WAIT:
					if (bc_done)
					begin
						if (idx_r == len_of(op_r) - 3'h1)
						begin
							if (c_rd)
							begin
								rd_data_r  <= bc_rdata;
								rd_valid_r <= 1'b1;
							end
							if (op_r == `FCD_OP_SECT_ER || op_r == `FCD_OP_SECT_ADD)
								win_r <= WIN_CYC;
							else if (op_r == `FCD_OP_SUSPEND)
								win_r <= 16'h0000;
							op_done_r <= 1'b1;
							st_r      <= S_IDLE;
						end
						else
						begin
							idx_r <= idx_r + 3'h1;
							st_r  <= S_ISSUE;
						end
					end
				default:
					st_r <= S_IDLE;
			endcase
		end
	end

	fcd_bus_cycle u_cyc
	(
		.clk         (clk),
		.resetn      (resetn),
		.start       (bc_start_r),
		.is_read     (bc_read_r),
		.addr        (bc_addr_r),
		.wdata       (bc_data_r),
		.done_r      (bc_done),
		.rdata_r     (bc_rdata),
		.f_addr_r    (f_addr),
		.f_ce_n_r    (f_ce_n),
		.f_we_n_r    (f_we_n),
		.f_oe_n_r    (f_oe_n),
		.f_dq_out_r  (f_dq_out),
		.f_dq_oe_n_r (f_dq_oe_n),
		.f_dq_in     (f_dq_in)
	);
endmodule // fcd_host

/* tb/fcd_flash_model.sv */
`include "fcd_consts.vh"

module fcd_flash_model #(
	parameter logic [15:0] ID1  = 16'h0000,
	parameter logic [15:0] ID2  = 16'h0000,
	parameter logic [15:0] ID3  = 16'h0000,
	parameter logic [15:0] SECR = 16'h0002
) (
	// Flash pins
	input  logic [20:0] f_addr,
	input  logic        f_ce_n,
	input  logic        f_we_n,
	input  logic        f_oe_n,
	input  logic [15:0] dq,
	output logic [15:0] m_dq,
	// Write log
	output logic        m_tgl,
	output logic [20:0] m_addr,
	output logic [15:0] m_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [20:0] a_l;
	logic        armed;
	logic        idm;
	logic [1:0]  st;
	logic [2:0]  bank;
	logic [15:0] rd;
	logic [15:0] rd_q;
	wire         strobe = f_ce_n | f_we_n;

	initial
	begin
		armed = 1'b0;
		idm = 1'b0;
		st = 2'h0;
		bank = 3'h0;
		rd_q = 16'h0000;
		m_tgl = 1'b0;
	end

	always @(negedge strobe)
	begin
		a_l = f_addr;
		armed = 1'b1;
	end

	// Only the low byte decides a command
	always @(posedge strobe)
		if (armed)
		begin
			armed = 1'b0;
			m_addr = a_l;
			m_data = dq;
			if (dq[7:0] == 8'hf0)
			begin
				idm = 1'b0;
				st = 2'h0;
			end
			else if (idm && dq[7:0] == 8'h00)
				idm = 1'b0;
			else if (st == 2'h0 && a_l[10:0] == 11'h555 && dq[7:0] == 8'haa)
				st = 2'h1;
			else if (st == 2'h1 && a_l[10:0] == 11'h2aa && dq[7:0] == 8'h55)
				st = 2'h2;
			else if (st == 2'h2 && dq[7:0] == 8'h90)
			begin
				idm = 1'b1;
				bank = a_l[20:18];
				st = 2'h0;
			end
			else
				st = 2'h0;
			m_tgl = ~m_tgl;
		end

	always @*
	begin
		rd = ~f_addr[15:0];
		if (idm && f_addr[20:18] == bank)
			case (f_addr[11:0])
				12'h001: rd = ID1;
				12'h00e: rd = ID2;
				12'h00f: rd = ID3;
				12'h002: rd = {15'h0000, f_addr[12]};
				12'h003: rd = SECR;
				default: ;
			endcase
	end

	// A released bus shows the inverse of the last value
	always @(posedge f_oe_n)
		rd_q <= rd;
	assign m_dq = (!f_ce_n && !f_oe_n) ? rd : ~rd_q;
endmodule // fcd_flash_model

/* tb/fcd_monitor.sv */
`include "fcd_consts.vh"

module fcd_monitor (
	// Clock and reset
	input logic               clk,
	input logic               resetn,
	// Request side
	input logic               op_valid,
	input logic               op_ready_r,
	input logic               op_done_r,
	input logic               rd_valid_r,
	input logic               window_open_r,
	// Flash pins
	input logic [`FCD_AW-1:0] f_addr,
	input logic               f_ce_n,
	input logic               f_we_n,
	input logic               f_oe_n,
	input logic [`FCD_DW-1:0] f_dq_out,
	input logic               f_dq_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [10:0] wcnt_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Length of the open collection window, restarted when a further sector reloads it
	always @(posedge clk or negedge resetn)
		if (!resetn)
			wcnt_r <= 11'h000;
		else
			wcnt_r <= (window_open_r && !op_done_r) ? wcnt_r + 11'h001 : 11'h000;

	sequence s_setup;
		(f_we_n && f_oe_n) [*2];
	endsequence
	sequence s_pulse;
		(!f_we_n || !f_oe_n) [*3];
	endsequence
	sequence s_recover;
		(f_we_n && f_oe_n) [*2];
	endsequence

	property p_strobe_excl;
		!(!f_we_n && !f_oe_n);
	endproperty
	property p_we_in_ce;
		!f_we_n |-> !f_ce_n && !f_dq_oe_n && $stable(f_dq_out);
	endproperty
	property p_addr_hold;
		!f_ce_n && !$past(f_ce_n) |-> $stable(f_addr);
	endproperty
	property p_cycle;
		$fell(f_ce_n) |-> s_setup ##1 s_pulse ##1 s_recover ##1 f_ce_n;
	endproperty
	property p_read_release;
		!f_oe_n |-> f_dq_oe_n && !f_ce_n;
	endproperty
	property p_take;
		op_valid && op_ready_r |=> !op_ready_r;
	endproperty
	property p_done_pulse;
		op_done_r |=> !op_done_r;
	endproperty
	property p_rd_with_done;
		rd_valid_r |-> op_done_r;
	endproperty
	property p_window_len;
		wcnt_r <= `FCD_WINDOW_CYC + 1;
	endproperty

	a_strobe_excl: assert property (p_strobe_excl) else $error("write and read strobes low together");
	a_we_in_ce: assert property (p_we_in_ce) else $error("write pulse without select or stable data");
	a_addr_hold: assert property (p_addr_hold) else $error("address moved inside a bus cycle");
	a_cycle: assert property (p_cycle) else $error("bus cycle framing wrong");
	a_read_release: assert property (p_read_release) else $error("host drives data during a read");
	a_take: assert property (p_take) else $error("ready stayed high after a take");
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	a_rd_with_done: assert property (p_rd_with_done) else $error("read data valid without done");
	a_window_len: assert property (p_window_len) else $error("collection window too long");
endmodule // fcd_monitor

bind fcd_host fcd_monitor u_mon (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op_ready_r(op_ready_r),
	.op_done_r(op_done_r), .rd_valid_r(rd_valid_r), .window_open_r(window_open_r), .f_addr(f_addr),
	.f_ce_n(f_ce_n), .f_we_n(f_we_n), .f_oe_n(f_oe_n), .f_dq_out(f_dq_out), .f_dq_oe_n(f_dq_oe_n));

/* tb/flash_command_decoder_test.sv */
`include "fcd_consts.vh"

module flash_command_decoder_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [20:0] m, a; logic [15:0] dm, d;} fcd_note_t;
	localparam logic [20:0] UL = 21'h0007ff, BM = 21'h1c0000, SM = 21'h1ff000, FM = 21'h1fffff;
	// Arbitrary identifier words
	localparam logic [15:0] ID1 = 16'h2a11, ID2 = 16'h2a0e, ID3 = 16'h2a0f, SEC = 16'h0042;
	logic        clk, resetn, op_valid, op_ready_r, op_done_r, rd_valid_r, window_open_r;
	logic        f_ce_n, f_we_n, f_oe_n, f_dq_oe_n, m_tgl, idm;
	logic [3:0]  op_code;
	logic [2:0]  bank;
	logic [20:0] op_addr, f_addr, m_addr, a;
	logic [15:0] op_data, rd_data_r, f_dq_out, dq, m_dq, m_data;
	logic [31:0] r;
	fcd_note_t   wq[$];
	fcd_note_t   e;
	logic [15:0] rq[$];
	int          bad_count, samples_checked, cyc, n;
	integer      seed = 32'h7585;

	assign dq = (f_dq_oe_n === 1'b0) ? f_dq_out : m_dq;

	fcd_host u_dut (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
		.op_data(op_data), .op_ready_r(op_ready_r), .op_done_r(op_done_r), .rd_data_r(rd_data_r),
		.rd_valid_r(rd_valid_r), .window_open_r(window_open_r), .f_addr(f_addr), .f_ce_n(f_ce_n),
		.f_we_n(f_we_n), .f_oe_n(f_oe_n), .f_dq_out(f_dq_out), .f_dq_oe_n(f_dq_oe_n), .f_dq_in(dq));
	fcd_flash_model #(.ID1(ID1), .ID2(ID2), .ID3(ID3), .SECR(SEC)) u_flash (.f_addr(f_addr),
		.f_ce_n(f_ce_n), .f_we_n(f_we_n), .f_oe_n(f_oe_n), .dq(dq), .m_dq(m_dq), .m_tgl(m_tgl),
		.m_addr(m_addr), .m_data(m_data));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task final_report;
		$display("compared %0d, mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	function logic [15:0] exp_rd(input logic [20:0] x);
		exp_rd = ~x[15:0];
		if (idm && x[20:18] == bank)
			case (x[11:0])
				12'h001: exp_rd = ID1;
				12'h00e: exp_rd = ID2;
				12'h00f: exp_rd = ID3;
				12'h002: exp_rd = {15'h0000, x[12]};
				12'h003: exp_rd = SEC;
				default: ;
			endcase
	endfunction

	task nt(input logic [20:0] m, input logic [20:0] x, input logic [15:0] d, input logic [15:0] dm = 16'h00ff);
		wq.push_back('{m, x, dm, d});
	endtask

	task unl;
		nt(UL, `FCD_ADDR_555, `FCD_D_UNLK1);
		nt(UL, `FCD_ADDR_2AA, `FCD_D_UNLK2);
	endtask

	// Note the expected cycles, then hand one operation over
	task do_op(input logic [3:0] c, input logic [20:0] x, input logic [15:0] d = 16'h0000);
		if (c inside {`FCD_OP_IDENT, `FCD_OP_SECR_IN, `FCD_OP_SECR_OUT, `FCD_OP_PROG, `FCD_OP_BYP_IN,
			`FCD_OP_CHIP_ER, `FCD_OP_SECT_ER})
			unl;
		if (c == `FCD_OP_CHIP_ER || c == `FCD_OP_SECT_ER)
		begin
			nt(UL, `FCD_ADDR_555, `FCD_D_ERASE);
			unl;
		end
		if (c == `FCD_OP_IDENT)
		begin
			idm = 1'b1;
			bank = x[20:18];
			nt(BM | UL, {x[20:18], 18'h00000} | `FCD_ADDR_555, `FCD_D_IDENT);
		end
		if (c == `FCD_OP_RESET || c == `FCD_OP_SECR_OUT)
			idm = 1'b0;
		case (c)
			`FCD_OP_RESET: nt(21'h0, 21'h0, `FCD_D_RESET);
			`FCD_OP_READ, `FCD_OP_IDENT: rq.push_back(exp_rd(x));
			`FCD_OP_SECR_IN: nt(UL, `FCD_ADDR_555, `FCD_D_SECR);
			`FCD_OP_SECR_OUT: nt(UL, `FCD_ADDR_555, `FCD_D_IDENT);
			`FCD_OP_PROG: nt(UL, `FCD_ADDR_555, `FCD_D_PROG);
			`FCD_OP_BYP_IN: nt(UL, `FCD_ADDR_555, `FCD_D_BYPASS);
			`FCD_OP_BYP_PROG: nt(21'h0, 21'h0, `FCD_D_PROG);
			`FCD_OP_BYP_OUT: nt(21'h0, 21'h0, `FCD_D_IDENT);
			`FCD_OP_CHIP_ER: nt(UL, `FCD_ADDR_555, `FCD_D_CHIP);
			`FCD_OP_SECT_ER, `FCD_OP_SECT_ADD: nt(SM, x, `FCD_D_SECT);
			`FCD_OP_SUSPEND: nt(BM, x, `FCD_D_SUSP);
			`FCD_OP_RESUME: nt(BM, x, `FCD_D_SECT);
			`FCD_OP_QUERY: nt(UL, `FCD_ADDR_55, `FCD_D_QUERY);
			default: ;
		endcase
		if (c == `FCD_OP_PROG || c == `FCD_OP_BYP_PROG)
			nt(FM, x, d, 16'hffff);
		if (c == `FCD_OP_SECR_OUT || c == `FCD_OP_BYP_OUT)
			nt(21'h0, 21'h0, `FCD_D_EXIT);
		@(posedge clk);
		#5;
		op_code = c;
		op_addr = x;
		op_data = d;
		op_valid = 1'b1;
		n = 0;
		while (op_ready_r !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			#5;
			n++;
		end
		@(posedge clk);
		#5;
		op_valid = 1'b0;
		n = 0;
		while (op_done_r !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			#5;
			n++;
		end
		check(n < 200, 1'b1);
	endtask

	always @(m_tgl)
		if (resetn === 1'b1)
		begin
			if (wq.size() == 0)
				check(1'b0, 1'b1);
			else
			begin
				e = wq.pop_front();
				check(m_addr & e.m, e.a & e.m);
				check(m_data & e.dm, e.d & e.dm);
			end
		end

	always @(negedge clk)
		if (rd_valid_r === 1'b1)
		begin
			if (rq.size() == 0)
				check(1'b0, 1'b1);
			else
				check(rd_data_r, rq.pop_front());
		end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			bad_count++;
			final_report;
		end
	end

	initial
	begin
		resetn = 1'b0;
		op_valid = 1'b0;
		op_code = 4'h0;
		op_addr = 21'h000000;
		op_data = 16'h0000;
		idm = 1'b0;
		bank = 3'h0;
		repeat (8) @(posedge clk);
		#5;
		resetn = 1'b1;
		r = $random(seed);
		a = r[20:0];
		do_op(`FCD_OP_READ, a);
		do_op(`FCD_OP_IDENT, {3'h5, 18'h00001});
		do_op(`FCD_OP_READ, {3'h5, 18'h0000e});
		do_op(`FCD_OP_READ, {3'h5, 18'h0000f});
		do_op(`FCD_OP_READ, {3'h5, 18'h01002});
		do_op(`FCD_OP_READ, {3'h5, 18'h02002});
		do_op(`FCD_OP_READ, {3'h5, 18'h00003});
		do_op(`FCD_OP_QUERY, a);
		do_op(`FCD_OP_RESET, a);
		do_op(`FCD_OP_READ, {3'h5, 18'h00001});
		do_op(`FCD_OP_SECR_IN, a);
		do_op(`FCD_OP_SECR_OUT, a);
		do_op(`FCD_OP_QUERY, a);
		r = $random(seed);
		do_op(`FCD_OP_PROG, r[20:0], r[31:16]);
		do_op(`FCD_OP_BYP_IN, a);
		repeat (2)
		begin
			r = $random(seed);
			do_op(`FCD_OP_BYP_PROG, r[20:0], r[31:16]);
		end
		do_op(`FCD_OP_BYP_OUT, a);
		do_op(`FCD_OP_CHIP_ER, a);
		do_op(`FCD_OP_SECT_ER, a);
		do_op(`FCD_OP_SECT_ADD, a ^ 21'h001000);
		n = 0;
		while (window_open_r === 1'b1 && n < 1100)
		begin
			@(posedge clk);
			#5;
			n++;
		end
		check(n > 990 && n <= `FCD_WINDOW_CYC, 1'b1);
		do_op(`FCD_OP_SECT_ER, a);
		do_op(`FCD_OP_SUSPEND, a);
		// The window flag is registered from the counter, so it drops one clock after done
		@(posedge clk);
		#5;
		check(window_open_r, 1'b0);
		do_op(`FCD_OP_RESUME, a);
		repeat (20) @(posedge clk);
		check(wq.size() + rq.size(), 0);
		final_report;
	end
endmodule // flash_command_decoder_test
